// *** logic/sac_ctrl.v ***
/*
 * control and result logic of a 12-bit successive-approximation converter,
 * reached as an apb slave, driving the analog core and the pin-mode controls.
 * assumes: pclk is the system oscillator; the analog core compares the sampled
 * input with trial_code and reports cmp_above one converter clock later; the
 * pwm unit gives its enable as a level synchronous to pclk.
 */
`timescale 1ns/1ps
`include "sac_consts.vh"

module sac_ctrl #(
	parameter ADDR_W = 12
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	input wire pwm_enable,
	input wire cmp_above,
	output reg core_enable_q,
	output reg sample_q,
	output reg [11:0] trial_code_q,
	output reg [3:0] channel_select_q,
	output reg channel_gate_q,
	output reg external_reference_enable_q,
	output reg supply_reference_force_q,
	output reg [1:0] internal_reference_select_q,
	output reg [7:0] port1_pure_analog_bits_q,
	output reg [1:0] port2_pure_analog_bits_q,
	output reg converter_irq_q
);

	// ==========================================================
	// state
	reg [1:0] clock_divider_select_q;
	reg pwm_trigger_enable_q;
	reg converter_irq_enable_q;
	reg converter_irq_flag_q;
	reg conversion_done_q;
	reg busy_q;
	reg [3:0] div_cnt_q;
	reg [5:0] tick_cnt_q;
	reg [11:0] mask_q;
	reg [11:0] result_q;

	// ==========================================================
	// apb decode
	wire wr_acc;
	wire [31:0] wd;
	reg [7:0] rd_byte;
	reg hit;
	reg [7:0] sel_idx;

	assign wr_acc = psel & penable & pwrite & pready_q;
	assign wd = pwdata;

	// word index from the byte address; low two bits must be zero
	always @* begin
		sel_idx = paddr[9:2];
		hit = 1'b1;
		rd_byte = `SAC_RST_8;
		if (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:10] != {(ADDR_W-10){1'b0}}) begin
			hit = 1'b0;
		end else if (sel_idx == `SAC_IDX_CTRL) begin
			rd_byte = {core_enable_q, busy_q, conversion_done_q, 1'b0, channel_select_q};
		end else if (sel_idx == `SAC_IDX_RES_HI) begin
			rd_byte = result_q[11:4];
		end else if (sel_idx == `SAC_IDX_RES_LO) begin
			rd_byte = {1'b0, channel_gate_q, clock_divider_select_q, result_q[3:0]};
		end else if (sel_idx == `SAC_IDX_REF) begin
			rd_byte = {external_reference_enable_q, 2'h0, pwm_trigger_enable_q, 1'b0,
				supply_reference_force_q, internal_reference_select_q};
		end else if (sel_idx == `SAC_IDX_P1AN) begin
			rd_byte = port1_pure_analog_bits_q;
		end else if (sel_idx == `SAC_IDX_P2AN) begin
			rd_byte = {6'h00, port2_pure_analog_bits_q};
		end else if (sel_idx == `SAC_IDX_IRQEN) begin
			rd_byte = {6'h00, converter_irq_enable_q, 1'b0};
		end else if (sel_idx == `SAC_IDX_IRQFL) begin
			rd_byte = {7'h00, converter_irq_flag_q};
		end else begin
			hit = 1'b0;
		end
	end

	// no wait state: answer registered in setup, pready in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready_q <= 1'b1;
			pslverr_q <= ~hit;
			prdata_q <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	wire wr_ok;
	assign wr_ok = wr_acc & ~pslverr_q;

	wire wr_ctrl;
	wire wr_rlo;
	wire wr_irqfl;
	assign wr_ctrl = wr_ok && sel_idx == `SAC_IDX_CTRL;
	assign wr_rlo = wr_ok && sel_idx == `SAC_IDX_RES_LO;
	assign wr_irqfl = wr_ok && sel_idx == `SAC_IDX_IRQFL;

	// ==========================================================
	// plain configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_enable_q <= 1'b0;
			channel_select_q <= `SAC_RST_4;
			channel_gate_q <= 1'b0;
			clock_divider_select_q <= `SAC_RST_2;
			external_reference_enable_q <= 1'b0;
			pwm_trigger_enable_q <= 1'b0;
			supply_reference_force_q <= 1'b0;
			internal_reference_select_q <= `SAC_RST_2;
			port1_pure_analog_bits_q <= `SAC_RST_8;
			port2_pure_analog_bits_q <= `SAC_RST_2;
			converter_irq_enable_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				core_enable_q <= wd[`SAC_CTRL_EN];
				channel_select_q <= wd[`SAC_CTRL_CHS_HI:0];
			end
			if (wr_rlo) begin
				channel_gate_q <= wd[`SAC_RLO_GATE];
				clock_divider_select_q <= wd[`SAC_RLO_CKS_HI:`SAC_RLO_CKS_LO];
			end
			if (wr_ok && sel_idx == `SAC_IDX_REF) begin
				external_reference_enable_q <= wd[`SAC_REF_EXT];
				pwm_trigger_enable_q <= wd[`SAC_REF_PWM];
				supply_reference_force_q <= wd[`SAC_REF_SUP];
				internal_reference_select_q <= wd[`SAC_REF_ISEL_HI:0];
			end
			if (wr_ok && sel_idx == `SAC_IDX_P1AN) begin
				port1_pure_analog_bits_q <= wd[7:0];
			end
			if (wr_ok && sel_idx == `SAC_IDX_P2AN) begin
				port2_pure_analog_bits_q <= wd[1:0];
			end
			if (wr_ok && sel_idx == `SAC_IDX_IRQEN) begin
				converter_irq_enable_q <= wd[`SAC_IRQEN_BIT];
			end
		end
	end

	// ==========================================================
	// converter clock divider, as a tick on pclk
	reg [3:0] div_max;
	always @* begin
		if (clock_divider_select_q == `SAC_CKS_DIV16) begin
			div_max = `SAC_DIVM_16;
		end else if (clock_divider_select_q == `SAC_CKS_DIV8) begin
			div_max = `SAC_DIVM_8;
		end else if (clock_divider_select_q == `SAC_CKS_DIV1) begin
			div_max = `SAC_DIVM_1;
		end else begin
			div_max = `SAC_DIVM_2;
		end
	end

	wire adc_tick;
	assign adc_tick = busy_q && (div_cnt_q >= div_max);

	// divider restarts with each conversion so timing is exact from the start
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= `SAC_RST_4;
		end else if (!busy_q || adc_tick) begin
			div_cnt_q <= `SAC_RST_4;
		end else begin
			div_cnt_q <= div_cnt_q + 4'h1;
		end
	end

	// ==========================================================
	// start sources and sequencing
	wire sw_start;
	wire pwm_start;
	wire start;
	wire [3:0] slot;
	wire slot_end;
	wire decide;
	wire last_tick;
	wire [11:0] kept;

	assign sw_start = wr_ctrl && wd[`SAC_CTRL_START] && wd[`SAC_CTRL_EN];
	assign pwm_start = pwm_trigger_enable_q && pwm_enable && core_enable_q;
	assign start = !busy_q && (sw_start || pwm_start);
	assign slot = tick_cnt_q[5:2];
	assign slot_end = adc_tick && tick_cnt_q[1:0] == `SAC_TICKS_PER_SLOT - 1;
	assign decide = slot_end && slot >= `SAC_SAMPLE_SLOTS;
	assign last_tick = adc_tick && tick_cnt_q == `SAC_SLOTS * `SAC_TICKS_PER_SLOT - 1;
	// keep the trial bit when the input is at or above the trial level
	assign kept = cmp_above ? trial_code_q : (trial_code_q & ~mask_q);

	// four sampling slots, then one bit per slot, msb first
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			tick_cnt_q <= 6'h00;
			sample_q <= 1'b0;
			mask_q <= 12'h000;
			trial_code_q <= 12'h000;
		end else if (start) begin
			busy_q <= 1'b1;
			tick_cnt_q <= 6'h00;
			sample_q <= 1'b1;
			mask_q <= `SAC_TRIAL_MSB;
			trial_code_q <= `SAC_TRIAL_MSB;
		end else if (busy_q && (!core_enable_q || (wr_ctrl && !wd[`SAC_CTRL_EN]))) begin
			// disabling mid conversion abandons it with no result, unless on the last tick; sampling stops
			// at the same edge as the enable bit, or one edge later when a pwm start meets the disabling write
			busy_q <= 1'b0;
			sample_q <= 1'b0;
		end else if (adc_tick) begin
			tick_cnt_q <= tick_cnt_q + 6'h01;
			if (slot_end && slot == `SAC_SAMPLE_SLOTS - 4'h1) begin
				sample_q <= 1'b0;
			end
			if (decide) begin
				trial_code_q <= kept | (mask_q >> 1);
				mask_q <= mask_q >> 1;
			end
			if (last_tick) begin
				busy_q <= 1'b0;
			end
		end
	end

	// result kept without reset: undefined until the first completion
	always @(posedge pclk) begin
		if (last_tick) begin
			result_q <= kept;
		end
	end

	// ==========================================================
	// done and interrupt flags: a completion wins over a firmware clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_done_q <= 1'b0;
			converter_irq_flag_q <= 1'b0;
			converter_irq_q <= 1'b0;
		end else begin
			if (last_tick) begin
				conversion_done_q <= 1'b1;
			end else if (start) begin
				conversion_done_q <= 1'b0;
			end else if (wr_ctrl && !wd[`SAC_CTRL_DONE]) begin
				conversion_done_q <= 1'b0;
			end
			if (last_tick) begin
				converter_irq_flag_q <= 1'b1;
			end else if (wr_irqfl && !wd[`SAC_IRQFL_BIT]) begin
				converter_irq_flag_q <= 1'b0;
			end
			converter_irq_q <= converter_irq_enable_q && converter_irq_flag_q;
		end
	end

endmodule // sac_ctrl

// *** logic/sac_consts.vh ***
/*
 * sar converter control: register indices, field positions, reset values and
 * conversion timing counts.
 * assumes: included by the converter control module only; definitions only.
 */
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define SAC_IDX_CTRL 8'hd2
`define SAC_IDX_RES_HI 8'hd3
`define SAC_IDX_RES_LO 8'hd4
`define SAC_IDX_REF 8'hd5
`define SAC_IDX_P1AN 8'hd6
`define SAC_IDX_P2AN 8'hd7
`define SAC_IDX_IRQEN 8'hd8
`define SAC_IDX_IRQFL 8'hd9

// ==========================================================
// converter_control fields
`define SAC_CTRL_EN 7
`define SAC_CTRL_START 6
`define SAC_CTRL_DONE 5
`define SAC_CTRL_CHS_HI 3
// result_low_clock_select fields
`define SAC_RLO_GATE 6
`define SAC_RLO_CKS_HI 5
`define SAC_RLO_CKS_LO 4
// reference_select fields
`define SAC_REF_EXT 7
`define SAC_REF_PWM 4
`define SAC_REF_SUP 2
`define SAC_REF_ISEL_HI 1
// interrupt enable and flag positions
`define SAC_IRQEN_BIT 1
`define SAC_IRQFL_BIT 0

// ==========================================================
// reset values and codes
`define SAC_RST_8 8'h00
`define SAC_RST_4 4'h0
`define SAC_RST_2 2'h0
`define SAC_CHS_BATT 4'ha
`define SAC_CKS_DIV16 2'h0
`define SAC_CKS_DIV8 2'h1
`define SAC_CKS_DIV1 2'h2
`define SAC_DIVM_16 4'hf
`define SAC_DIVM_8 4'h7
`define SAC_DIVM_2 4'h1
`define SAC_DIVM_1 4'h0

// ==========================================================
// conversion timing: 16 slots of 4 converter clocks each
`define SAC_TICKS_PER_SLOT 4
`define SAC_SLOTS 16
`define SAC_SAMPLE_SLOTS 4'h4
`define SAC_TRIAL_MSB 12'h800

`endif

// *** tb/sac_ctrl_sva.sv ***
/* checker on the ports of the converter control block.
   assumes: apb writes land at the access edge, one access cycle each. */
`timescale 1ns/1ps
// ==========================================
// port checker
module sac_chk #(
	parameter ADDR_W = 12
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata_q,
	input wire pready_q,
	input wire pslverr_q,
	input wire core_enable_q,
	input wire sample_q,
	input wire [11:0] trial_code_q,
	input wire channel_gate_q,
	input wire [3:0] channel_select_q,
	input wire external_reference_enable_q,
	input wire supply_reference_force_q,
	input wire [1:0] internal_reference_select_q,
	input wire [7:0] port1_pure_analog_bits_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed write, the only moment a configuration register may change
	wire wr = psel && penable && pready_q && pwrite;
	ready_after_setup_a: assert property (psel && !penable |=> pready_q) else $error("no ready after setup");
	ready_single_a: assert property (pready_q |=> !pready_q) else $error("ready held too long");
	err_with_ready_a: assert property (pslverr_q |-> pready_q) else $error("error without ready");
	rdata_upper_a: assert property (pready_q && !pwrite |-> prdata_q[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	enable_write_a: assert property (wr && paddr == 12'h348 && (pwdata[7] || !pwdata[6])
		|=> core_enable_q == $past(pwdata[7])) else $error("enable not written");
	enable_hold_a: assert property (!wr |=> $stable(core_enable_q)) else $error("enable moved");
	sample_needs_en_a: assert property (sample_q |-> core_enable_q) else $error("sampling while off");
	first_trial_a: assert property ($rose(sample_q) |-> trial_code_q == 12'h800) else $error("bad first trial");
	gate_write_a: assert property (wr && paddr == 12'h350 |=> channel_gate_q == $past(pwdata[6]))
		else $error("gate not written");
	port1_write_a: assert property (wr && paddr == 12'h358 |=> port1_pure_analog_bits_q == $past(pwdata[7:0]))
		else $error("port1 not written");
	chs_write_a: assert property (wr && paddr == 12'h348 |=> channel_select_q == $past(pwdata[3:0]))
		else $error("channel not written");
	ref_write_a: assert property (wr && paddr == 12'h354 |=> {external_reference_enable_q, supply_reference_force_q,
		internal_reference_select_q} == $past({pwdata[7], pwdata[2], pwdata[1:0]}))
		else $error("reference not written");
endmodule // sac_chk

bind sac_ctrl sac_chk #(.ADDR_W(ADDR_W)) u_sac_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
	.pready_q(pready_q), .pslverr_q(pslverr_q), .core_enable_q(core_enable_q), .sample_q(sample_q),
	.trial_code_q(trial_code_q), .channel_gate_q(channel_gate_q), .channel_select_q(channel_select_q),
	.external_reference_enable_q(external_reference_enable_q), .supply_reference_force_q(supply_reference_force_q),
	.internal_reference_select_q(internal_reference_select_q),
	.port1_pure_analog_bits_q(port1_pure_analog_bits_q));

// *** tb/sac_analog_model.sv ***
/* behavioural comparator of the analog core.
   assumes: the bench sets the input level as a 12-bit code of the reference. */
`timescale 1ns/1ps
// ==========================================
// comparator model
module sac_analog_model (
	input wire pclk,
	input wire enable,
	input wire [11:0] trial,
	input wire [11:0] level,
	output wire cmp_above
);
	reg junk_q = 1'b0;
	// switched-off core: toggle so no decision settles by luck
	always @(posedge pclk) junk_q <= ~junk_q;
	// at or above the trial code reads one, straight binary
	assign cmp_above = enable ? (level >= trial) : junk_q;
endmodule // sac_analog_model

// *** tb/test_sac_ctrl.sv ***
/* self-checking bench of the converter control block.
   assumes: apb slave answers after setup; comparator model on the far side. */
`timescale 1ns/1ps
// ==========================================
// bench top
module test_sac_ctrl;
	localparam [11:0] CT = 12'h348, RH = 12'h34c, RL = 12'h350, RF = 12'h354;
	localparam [11:0] P1 = 12'h358, IE = 12'h360, IF = 12'h364;
	reg pclk, presetn, psel, penable, pwrite, pwm_enable;
	reg [11:0] paddr, level, lv;
	reg [31:0] pwdata;
	wire [31:0] prdata_q;
	wire pready_q, pslverr_q, cmp_above, core_enable_q, converter_irq_q;
	wire [11:0] trial_code_q;
	reg [8:0] q[$];
	reg [7:0] v;
	reg [3:0] chs;
	integer num_errors = 0, samples_checked = 0, seed, k, dv;
	sac_ctrl u_sac_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.pwm_enable(pwm_enable), .cmp_above(cmp_above), .core_enable_q(core_enable_q), .sample_q(),
		.trial_code_q(trial_code_q), .channel_select_q(), .channel_gate_q(), .external_reference_enable_q(),
		.supply_reference_force_q(), .internal_reference_select_q(), .port1_pure_analog_bits_q(),
		.port2_pure_analog_bits_q(), .converter_irq_q(converter_irq_q));
	sac_analog_model u_sac_analog_model (.pclk(pclk), .enable(core_enable_q), .trial(trial_code_q),
		.level(level), .cmp_above(cmp_above));
	// ==========================================
	// reporting
	task err(input [255:0] m);
		begin
			$display("[ERR] %0t %0s", $time, m);
			num_errors = num_errors + 1;
		end
	endtask
	task conclude;
		begin
			$display("checked %0d errors %0d", samples_checked, num_errors);
			if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task cmp_rd(input [31:0] d, input e);
		reg [8:0] x;
		begin
			x = q.pop_front();
			samples_checked = samples_checked + 1;
			if ({e, d} !== {x[8], 24'h00_0000, x[7:0]}) err("read data mismatch");
		end
	endtask
	task cmp_num(input integer n, lo, hi);
		begin
			samples_checked = samples_checked + 1;
			if (n < lo || n > hi) err("cycle count out of range");
		end
	endtask
	// ==========================================
	// apb master: request held until ready is sampled
	task apb(input [11:0] a, input [7:0] d, input w, input [7:0] e, input er);
		integer n;
		begin
			@(posedge pclk);
			{psel, penable, pwrite} <= {2'b10, w};
			paddr <= a;
			pwdata <= {24'h00_0000, d};
			if (!w) q.push_back({er, e});
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			do begin @(posedge pclk); n = n + 1; end while (pready_q !== 1'b1 && n < 50);
			{psel, penable} <= 2'b00;
			if (n >= 50) begin err("apb hang"); conclude; end
		end
	endtask
	task wr(input [11:0] a, input [7:0] d); apb(a, d, 1'b1, 8'h00, 1'b0); endtask
	task rd(input [11:0] a, input [7:0] e); apb(a, 8'h00, 1'b0, e, 1'b0); endtask
	// bounded wait for the interrupt line to reach a level
	task wait_irq(input b, input integer lo, hi);
		integer n;
		begin
			n = 0;
			do begin @(posedge pclk); n = n + 1; end while (converter_irq_q !== b && n < 3000);
			cmp_num(n, lo, hi);
			if (n >= 3000) conclude;
		end
	endtask
	// read monitor takes the oldest note
	always @(posedge pclk) if (psel && penable && pready_q === 1'b1 && !pwrite) cmp_rd(prdata_q, pslverr_q);
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, pwm_enable} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		level = 12'h000;
		seed = 33;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(P1, 8'h00);
		rd(CT, 8'h00);
		v = $random(seed);
		wr(P1, v);
		rd(P1, v);
		wr(RF, v & 8'h97);
		rd(RF, v & 8'h97);
		apb(12'h3fc, 8'h00, 1'b0, 8'h00, 1'b1);
		apb(12'h349, 8'h00, 1'b0, 8'h00, 1'b1);
		$display("test registers done");
		wr(IE, 8'h02);
		wr(RF, 8'h04);
		// every divider code, battery channel last
		for (k = 0; k < 4; k = k + 1) begin
			dv = (k == 0) ? 16 : (k == 1) ? 8 : (k == 2) ? 1 : 2;
			chs = (k == 3) ? 4'ha : k * 3;
			lv = $random(seed);
			level <= lv;
			wr(RL, {2'b01, k[1:0], 4'h0});
			wr(CT, {4'hc, chs});
			rd(CT, {4'hc, chs});
			wait_irq(1'b1, 64 * dv - 5, 64 * dv + 2);
			rd(CT, {4'ha, chs});
			wr(RH, 8'hff);
			rd(RH, lv[11:4]);
			rd(RL, {2'b01, k[1:0], lv[3:0]});
			rd(IF, 8'h01);
			wr(IF, 8'h00);
			wait_irq(1'b0, 1, 3);
			wr(CT, {4'h8, chs});
			rd(CT, {4'h8, chs});
		end
		$display("test conversions done");
		wr(CT, 8'hc1);
		wr(CT, 8'h01);
		wr(CT, 8'h41);
		repeat (150) @(posedge pclk);
		rd(CT, 8'h01);
		rd(IF, 8'h00);
		$display("test abort done");
		wr(CT, 8'h80);
		pwm_enable <= 1'b1;
		repeat (150) @(posedge pclk);
		rd(IF, 8'h00);
		wr(RF, 8'h14);
		wait_irq(1'b1, 127, 132);
		wr(IF, 8'h00);
		wait_irq(1'b0, 1, 3);
		wait_irq(1'b1, 100, 135);
		wr(IE, 8'h00);
		wait_irq(1'b0, 1, 3);
		rd(IF, 8'h01);
		pwm_enable <= 1'b0;
		$display("test pwm done");
		conclude;
	end
endmodule // test_sac_ctrl
